// >>> test/isa_parallel_printer_port_pins_test.sv
// Self-checking bench for the parallel printer port.
// Assumes ppp_pkg and the port design are compiled first.
`timescale 1ns/1ps
module isa_parallel_printer_port_pins_test;
  import ppp_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, cs_n = 1'b1, ior_n = 1'b1, iow_n = 1'b1;
  logic       aen = 1'b0, ext = 1'b0, tc = 1'b0, err_n = 1'b1, slct = 1'b1, pe = 1'b0;
  logic [2:0] addr = 3'h0, dack_n = 3'h7;
  logic [7:0] din = 8'h00, v, r, e;
  logic [1:0] dma_sel = 2'h0, irq_sel = 2'h3;
  logic [5:0] ack_wait = 6'h04;
  logic [7:0] dout, pd_out, rev, got_byte;
  logic [2:0] drq, drq_oe, irq_n, irq_oe;
  logic       data_oe, iochrdy, iochrdy_oe, pd_oe, dir_ind, strobe_n, afd_n, init_n, sel_n;
  logic       busy, ack_n, got, printing = 1'b0, irq_seen = 1'b0;
  int         fails = 0, n_compared = 0, seed, ch, i;
  logic [7:0] exp_q[$];
  wire  [7:0] pd_in = pd_oe ? pd_out : rev;

  ppp_port ppp_port_inst (.CLK(clk), .RST(rst), .CS_N(cs_n), .IOR_N(ior_n), .IOW_N(iow_n),
    .AEN(aen), .ADDR(addr), .EXTENDED_PORT_SELECT(ext), .DATA_IN(din), .DATA_OUT(dout),
    .DATA_OE(data_oe), .IOCHRDY(iochrdy), .IOCHRDY_OE(iochrdy_oe), .DMA_SELECT(dma_sel),
    .DACK_N(dack_n), .TC(tc), .DRQ(drq), .DRQ_OE(drq_oe), .IRQ_SELECT(irq_sel),
    .IRQ_N(irq_n), .IRQ_OE(irq_oe), .PERIPHERAL_DATA_LINES_IN(pd_in),
    .PERIPHERAL_DATA_LINES_OUT(pd_out), .PERIPHERAL_DATA_LINES_OE(pd_oe),
    .PORT_DIRECTION_INDICATOR(dir_ind), .STROBE_N(strobe_n), .AUTO_LINE_FEED_N(afd_n),
    .INIT_N(init_n), .PRINTER_SELECT_OUT_N(sel_n), .ERROR_N(err_n), .SLCT(slct),
    .BUSY(busy), .ACK_N(ack_n), .PE(pe));

  ppp_printer_model ppp_printer_model_inst (.CLK(clk), .STROBE_N(strobe_n), .PD(pd_out),
    .ACK_WAIT(ack_wait), .BUSY(busy), .ACK_N(ack_n), .REV_DATA(rev), .GOT(got),
    .GOT_BYTE(got_byte));

  // Clock at 100 MHz.
  initial begin
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expd);
    n_compared++;
    if (seen !== expd) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, expd, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  // One host cycle: hold the strobe until ready is released, then idle a cycle.
  task automatic host(input logic wr, input logic x, input logic [2:0] a,
                      input logic [7:0] d, output logic [7:0] rd);
    int n;
    int w;
    w = 0;
    ext = x;
    addr = a;
    din = d;
    cs_n = 1'b0;
    if (wr) iow_n = 1'b0;
    else ior_n = 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (iochrdy_oe === 1'b1) w++;
      else if (w > 0) break;
    end
    if (n == 40) begin
      fails++;
      report_and_stop();
    end
    rd = dout;
    check("wait states", 8'(w), 8'(HOST_WAIT_CYC));
    check("ready level", 8'(iochrdy), 8'h00);
    check("host drive", 8'(data_oe), 8'(!wr));
    #1 iow_n = 1'b1;
    ior_n = 1'b1;
    cs_n = 1'b1;
    @(posedge clk);
    #1;
  endtask : host

  // A write that must be ignored: chip select off or a DMA cycle in progress.
  task automatic ghost(input logic c, input logic ae);
    cs_n = c;
    aen = ae;
    addr = 3'h0;
    ext = 1'b0;
    din = 8'hc3;
    iow_n = 1'b0;
    repeat (8) @(posedge clk);
    #1 iow_n = 1'b1;
    cs_n = 1'b1;
    aen = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : ghost

  // One DMA write byte; terminal count may ride on it.
  task automatic dma(input logic [7:0] b, input logic t);
    int n;
    for (n = 0; n < 60 && drq[ch] !== 1'b1; n++) @(posedge clk);
    if (n == 60) begin
      fails++;
      report_and_stop();
    end
    repeat (3) @(posedge clk);
    check("request held", 8'(drq[ch]), 8'h01);
    #1 aen = 1'b1;
    dack_n[ch] = 1'b0;
    iow_n = 1'b0;
    din = b;
    tc = t;
    for (n = 0; n < 60 && drq[ch] !== 1'b0; n++) @(posedge clk);
    if (n == 60) begin
      fails++;
      report_and_stop();
    end
    #1 iow_n = 1'b1;
    @(posedge clk);
    #1 aen = 1'b0;
    dack_n = 3'h7;
    tc = 1'b0;
    exp_q.push_back(b);
  endtask : dma

  // Wait until every expected byte has reached the printer.
  task automatic drain;
    int n;
    for (n = 0; n < 5000 && exp_q.size() > 0; n++) begin
      @(posedge clk);
      if (irq_n === 3'h0) irq_seen = 1'b1;
    end
    if (n == 5000) begin
      fails++;
      report_and_stop();
    end
    #1;
  endtask : drain

  // Once printing is set, each byte the printer takes must be the next one the host sent.
  always @(posedge clk) begin
    if (got === 1'b1 && printing) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      check("printed byte", got_byte, e);
    end
  end

  // A hung run is cut short and counted as a mismatch.
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    seed = 32'hc09a1230;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    check("reset lines", {pd_oe, dir_ind, strobe_n, afd_n, init_n, sel_n, 2'h3}, 8'hbf);
    check("reset drq", {drq, iochrdy_oe, 4'h0}, 8'h00);
    for (i = 0; i < 4; i++) begin
      v = 8'($random(seed)) & 8'h0f;
      host(1'b1, 1'b0, 3'h2, v, r);
      @(posedge clk);
      #1 check("control pins", {4'h0, ~sel_n, init_n, ~afd_n, ~strobe_n}, v);
      host(1'b0, 1'b0, 3'h2, 8'h00, r);
      check("control read", r & 8'h0f, v);
    end
    host(1'b1, 1'b0, 3'h2, 8'h04, r);
    v = 8'($random(seed)) & 8'h7f;
    host(1'b1, 1'b0, 3'h0, v, r);
    host(1'b1, 1'b0, 3'h2, 8'h24, r);
    ghost(1'b1, 1'b0);
    ghost(1'b0, 1'b1);
    check("latched data", pd_out, v);
    check("drive only", {pd_oe, dir_ind}, 8'h02);
    {err_n, slct, pe} = 3'($random(seed));
    repeat (30) @(posedge clk);
    #1 host(1'b0, 1'b0, 3'h1, 8'h00, r);
    check("status", r, {~busy, ack_n, pe, slct, err_n, 3'h7});
    host(1'b0, 1'b0, 3'h3, 8'h00, r);
    check("unmapped", r, UNMAPPED_RD);
    host(1'b1, 1'b1, 3'h2, {M_PS2, 5'h00}, r);
    repeat (3) @(posedge clk);
    #1 check("input mode", {pd_oe, dir_ind}, 8'h01);
    host(1'b0, 1'b0, 3'h0, 8'h00, r);
    check("reverse data", r, rev);
    irq_sel = 2'($unsigned($random(seed)) % 3);
    host(1'b1, 1'b0, 3'h2, 8'h14, r);
    host(1'b1, 1'b1, 3'h2, {M_PFIFO, 5'h00}, r);
    check("irq route", irq_oe, 3'(3'h1 << irq_sel));
    host(1'b0, 1'b1, 3'h2, 8'h00, r);
    check("fifo mode empty", {r[7:5], r[0]}, {M_PFIFO, 1'b1});
    printing = 1'b1;
    ack_wait = 6'($random(seed));
    for (i = 0; i < 5; i++) begin
      v = 8'($random(seed));
      exp_q.push_back(v);
      host(1'b1, 1'b1, 3'h0, v, r);
    end
    drain();
    check("irq level", 8'(irq_seen), 8'h01);
    ch = $unsigned($random(seed)) % 3;
    dma_sel = 2'(ch);
    ack_wait = 6'h02;
    host(1'b1, 1'b1, 3'h2, {M_PFIFO, 5'h08}, r);
    check("drq route", drq_oe, 3'(3'h1 << ch));
    for (i = 0; i < 4; i++) dma(8'($random(seed)), i == 3);
    repeat (30) @(posedge clk);
    #1 check("stop on count", drq, 3'h0);
    drain();
    irq_sel = SEL_NONE;
    repeat (2) @(posedge clk);
    #1 check("irq released", irq_oe, 3'h0);
    report_and_stop();
  end
endmodule : isa_parallel_printer_port_pins_test

// >>> test/ppp_printer_model.sv
// Behavioural printer on the far side of the parallel printer port.
// Assumes strobe and data come from flops clocked by CLK.
`timescale 1ns/1ps
module ppp_printer_model (
  input  wire logic       CLK,
  input  wire logic       STROBE_N,
  input  wire logic [7:0] PD,
  input  wire logic [5:0] ACK_WAIT,
  output logic            BUSY,
  output logic            ACK_N,
  output logic [7:0]      REV_DATA,
  output logic            GOT,
  output logic [7:0]      GOT_BYTE
);
  // Idle printer: ready, no acknowledge, a pattern offered for reverse reads.
  // Then take a byte per strobe, stay busy a while, then pulse acknowledge.
  // One process owns every output, so no signal has two drivers.
  // The wait is set by the bench so both prompt and slow printers are seen.
  initial begin
    BUSY = 1'b0;
    ACK_N = 1'b1;
    REV_DATA = 8'h5a;
    GOT = 1'b0;
    GOT_BYTE = 8'h00;
    forever begin
      @(negedge STROBE_N);
      @(posedge CLK);
      #1 GOT_BYTE = PD;
      GOT = 1'b1;
      BUSY = 1'b1;
      @(posedge CLK);
      #1 GOT = 1'b0;
      repeat (ACK_WAIT) @(posedge CLK);
      #1 ACK_N = 1'b0;
      repeat (3) @(posedge CLK);
      #1 ACK_N = 1'b1;
      BUSY = 1'b0;
      REV_DATA = REV_DATA + 8'h35;
    end
  end
endmodule : ppp_printer_model

// >>> verilog/ppp_mem.sv
// FIFO storage for the parallel printer port, with registered read data.
// Assumes the controller keeps the read address steady one cycle before use.
`timescale 1ns/1ps
module ppp_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input logic          clk,
  ppp_mem_if.mem       port
);
  logic [W-1:0] store [DEPTH];

  // Write on enable; read data always lags its address by one cycle.
  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
    port.rd_data <= store[port.rd_addr];
  end
endmodule : ppp_mem

// >>> verilog/ppp_mem_if.sv
// Carrier between the port logic and its FIFO storage.
// Assumes one writer and one reader in the same clock domain.
`timescale 1ns/1ps
interface ppp_mem_if #(
  parameter int W  = 8,
  parameter int AW = 4
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [W-1:0]  wr_data;
  logic [AW-1:0] rd_addr;
  logic [W-1:0]  rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : ppp_mem_if

// >>> verilog/ppp_pkg.sv
// Shared constants and types for the parallel printer port.
// Assumes a single 100 MHz clock; all host-side pins are synchronous to it.
package ppp_pkg;

  // Clock rates in MHz; the timing engines run on a tick near the reference rate.
  localparam int CLK_MHZ      = 100;
  localparam int REF_MHZ      = 24;
  localparam int TICK_CYC     = CLK_MHZ / REF_MHZ;  // Rounds down, tick is never slower.

  // Host wait states and printer strobe timing.
  localparam int HOST_WAIT_NS  = 40;
  localparam int HOST_WAIT_CYC = (HOST_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_NS     = 500;
  localparam int STROBE_TICKS  = (STROBE_NS * REF_MHZ + 999) / 1000;

  // FIFO geometry.
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = 4;

  // Address map: the extended bank sits this far above the base.
  localparam logic [10:0] EXT_OFFSET  = 11'h400;
  localparam logic [2:0]  OFS_DATA    = 3'h0;
  localparam logic [2:0]  OFS_STATUS  = 3'h1;
  localparam logic [2:0]  OFS_CONTROL = 3'h2;
  localparam logic [2:0]  OFS_FIFO    = 3'h0;
  localparam logic [2:0]  OFS_ECR     = 3'h2;

  // Control register fields.
  localparam int DCR_STROBE = 0;
  localparam int DCR_LFEED  = 1;
  localparam int DCR_INIT   = 2;
  localparam int DCR_SELIN  = 3;
  localparam int DCR_ACKIE  = 4;
  localparam int DCR_DIR    = 5;

  // Extended control register fields.
  localparam int ECR_MODE_LSB = 5;
  localparam int ECR_DMAEN    = 3;

  // Reset values and fixed read bits.
  localparam logic [7:0] DCR_RST     = 8'h04;
  localparam logic [7:0] ECR_RST     = 8'h00;
  localparam logic [2:0] STATUS_RSVD = 3'h7;
  localparam logic [7:0] UNMAPPED_RD = 8'hff;

  // Channel select code that selects nothing.
  localparam logic [1:0] SEL_NONE = 2'h3;

  typedef enum logic [2:0] {
    M_SPP   = 3'b000,
    M_PS2   = 3'b001,
    M_PFIFO = 3'b010,
    M_ECP   = 3'b011,
    M_EPP   = 3'b100,
    M_RSVD  = 3'b101,
    M_TEST  = 3'b110,
    M_CFG   = 3'b111
  } ppp_mode_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_WAIT = 2'b01,
    H_DONE = 2'b10
  } ppp_host_t;

  typedef enum logic [2:0] {
    P_IDLE   = 3'b000,
    P_LOAD   = 3'b001,
    P_SETUP  = 3'b010,
    P_STROBE = 3'b011,
    P_HOLD   = 3'b100
  } ppp_eng_t;

  // Modes whose data lines may only ever drive.
  function automatic logic mode_out_only(input logic [2:0] m);
    return (m == M_SPP) || (m == M_PFIFO);
  endfunction : mode_out_only

  // Modes in which the FIFO is in use.
  function automatic logic mode_fifo(input logic [2:0] m);
    return (m == M_PFIFO) || (m == M_ECP) || (m == M_TEST);
  endfunction : mode_fifo

  // One-hot decode of a channel select; the spare code selects nothing.
  function automatic logic [2:0] chan_onehot(input logic [1:0] sel);
    return (sel == SEL_NONE) ? 3'h0 : 3'(3'h1 << sel);
  endfunction : chan_onehot

endpackage : ppp_pkg

// >>> verilog/ppp_port.sv
// Parallel printer port: host I/O slave, DMA requester, FIFO and printer engine.
// Assumes all inputs are synchronous to CLK except the printer-side pins.
`timescale 1ns/1ps
module ppp_port import ppp_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int AW    = FIFO_AW
) (
  input  logic       CLK,
  input  logic       RST,
  input  logic       CS_N,
  input  logic       IOR_N,
  input  logic       IOW_N,
  input  logic       AEN,
  input  logic [2:0] ADDR,
  input  logic       EXTENDED_PORT_SELECT,
  input  logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic       DATA_OE,
  output logic       IOCHRDY,
  output logic       IOCHRDY_OE,
  input  logic [1:0] DMA_SELECT,
  input  logic [2:0] DACK_N,
  input  logic       TC,
  output logic [2:0] DRQ,
  output logic [2:0] DRQ_OE,
  input  logic [1:0] IRQ_SELECT,
  output logic [2:0] IRQ_N,
  output logic [2:0] IRQ_OE,
  input  logic [7:0] PERIPHERAL_DATA_LINES_IN,
  output logic [7:0] PERIPHERAL_DATA_LINES_OUT,
  output logic       PERIPHERAL_DATA_LINES_OE,
  output logic       PORT_DIRECTION_INDICATOR,
  output logic       STROBE_N,
  output logic       AUTO_LINE_FEED_N,
  output logic       INIT_N,
  output logic       PRINTER_SELECT_OUT_N,
  input  logic       ERROR_N,
  input  logic       SLCT,
  input  logic       BUSY,
  input  logic       ACK_N,
  input  logic       PE
);
  typedef struct packed {
    ppp_host_t     st;
    logic [2:0]    cnt;
    logic          rd;
    logic          ext;
    logic [2:0]    ofs;
    logic [7:0]    data;
    logic [7:0]    dcr;
    logic [7:0]    ecr;
    logic [7:0]    rdata;
    logic          doe;
    logic          wt;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   fill;
    logic          drq;
    logic          tcd;
    logic          iow_p;
    logic          ior_p;
    logic [7:0]    wl;
  } ppp_hs_t;

  typedef struct packed {
    ppp_eng_t   st;
    logic [4:0] tcnt;
    logic [7:0] pdat;
    logic       ack_p;
  } ppp_es_t;

  typedef struct packed {
    logic [7:0] pd;
    logic       pd_oe;
    logic       dir_ind;
    logic       stb_n;
    logic       afd_n;
    logic       init_n;
    logic       sel_n;
    logic [2:0] irq_n;
    logic [2:0] irq_oe;
    logic [2:0] drq;
    logic [2:0] drq_oe;
  } ppp_ps_t;

  localparam ppp_hs_t HS_RST = '{st: H_IDLE, dcr: DCR_RST, ecr: ECR_RST, iow_p: 1'b1,
                                 ior_p: 1'b1, default: '0};
  localparam ppp_es_t ES_RST = '{st: P_IDLE, ack_p: 1'b1, default: '0};
  localparam ppp_ps_t PS_RST = '{pd_oe: 1'b1, stb_n: 1'b1, afd_n: 1'b1, init_n: DCR_RST[DCR_INIT],
                                 sel_n: 1'b1, irq_n: 3'h7, default: '0};

  ppp_hs_t     hs_reg, hs_next;
  ppp_es_t     es_reg, es_next;
  ppp_ps_t     ps_reg, ps_next;
  logic [12:0] sync1_reg, sync2_reg;
  logic [2:0]  tick_cnt_reg, tick_cnt_next;
  logic        tick_reg, tick_next;
  logic        eng_push, eng_pop, push, pop, full, empty, fwd, dack_act, host_req;
  logic [2:0]  mode;
  logic [7:0]  pd_s, rd_mux;
  logic        err_s, slct_s, busy_s, ack_s, pe_s;

  ppp_mem_if #(.W(8), .AW(AW)) mif ();

  ppp_mem #(.W(8), .DEPTH(DEPTH)) u_mem (
    .clk  (CLK),
    .port (mif)
  );

  // Two-stage synchroniser for every printer-side input; only stage two is used.
  always_ff @(posedge CLK) begin
    if (RST) begin
      sync1_reg <= 13'h1fff;
      sync2_reg <= 13'h1fff;
    end else begin
      sync1_reg <= {PERIPHERAL_DATA_LINES_IN, ERROR_N, SLCT, BUSY, ACK_N, PE};
      sync2_reg <= sync1_reg;
    end
  end
  assign {pd_s, err_s, slct_s, busy_s, ack_s, pe_s} = sync2_reg;

  // Divider giving a one-cycle tick at roughly the reference rate.
  always_comb begin
    tick_next     = (tick_cnt_reg == 3'(TICK_CYC - 1));
    tick_cnt_next = tick_next ? 3'h0 : tick_cnt_reg + 3'h1;
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      tick_cnt_reg <= 3'h0;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  assign mode     = hs_reg.ecr[ECR_MODE_LSB +: 3];
  assign full     = (hs_reg.fill == (AW+1)'(DEPTH));
  assign empty    = (hs_reg.fill == '0);
  assign fwd      = ((mode == M_PFIFO) || (mode == M_ECP)) && !hs_reg.dcr[DCR_DIR];
  assign dack_act = AEN && (DMA_SELECT != SEL_NONE) && !DACK_N[DMA_SELECT];
  assign host_req = !CS_N && !AEN && (!IOR_N || !IOW_N);
  assign mif.rd_addr = hs_reg.rp;

  // Read multiplexer; the upper bank is picked by the extended select.
  always_comb begin
    rd_mux = UNMAPPED_RD;
    if (!hs_reg.ext) begin
      unique case (hs_reg.ofs)
        OFS_DATA:    rd_mux = (!mode_out_only(mode) && hs_reg.dcr[DCR_DIR]) ? pd_s : hs_reg.data;
        OFS_STATUS:  rd_mux = {!busy_s, ack_s, pe_s, slct_s, err_s, STATUS_RSVD};
        OFS_CONTROL: rd_mux = {2'b00, hs_reg.dcr[5:0]};
        default:     rd_mux = UNMAPPED_RD;
      endcase
    end else if (hs_reg.ofs == OFS_FIFO) begin
      rd_mux = mif.rd_data;
    end else if (hs_reg.ofs == OFS_ECR) begin
      rd_mux = {hs_reg.ecr[7:2], full, empty};
    end
  end

  // Host access, register file, DMA requester and FIFO pointers.
  always_comb begin
    hs_next       = hs_reg;
    push          = 1'b0;
    pop           = 1'b0;
    hs_next.iow_p = IOW_N;
    hs_next.ior_p = IOR_N;
    if (!IOW_N) begin
      hs_next.wl = DATA_IN;
    end
    unique case (hs_reg.st)
      H_IDLE: if (host_req) begin
        hs_next.st  = H_WAIT;
        hs_next.cnt = 3'h0;
        hs_next.rd  = !IOR_N;
        hs_next.ext = EXTENDED_PORT_SELECT;
        hs_next.ofs = ADDR;
        hs_next.wt  = 1'b1;
      end
      H_WAIT: if (hs_reg.cnt == 3'(HOST_WAIT_CYC - 1)) begin
        hs_next.st = H_DONE;
        hs_next.wt = 1'b0;
        if (hs_reg.rd) begin
          hs_next.rdata = rd_mux;
          hs_next.doe   = 1'b1;
          pop = hs_reg.ext && hs_reg.ofs == OFS_FIFO && mode_fifo(mode) && !empty
                && (hs_reg.dcr[DCR_DIR] || mode == M_TEST);
        end else if (!hs_reg.ext) begin
          if (hs_reg.ofs == OFS_DATA) begin
            hs_next.data = hs_reg.wl;
            push = (mode == M_ECP) && !full && !hs_reg.dcr[DCR_DIR];
          end
          if (hs_reg.ofs == OFS_CONTROL) begin
            hs_next.dcr = {2'b00, hs_reg.wl[5:0]};
          end
        end else if (hs_reg.ofs == OFS_FIFO) begin
          push = mode_fifo(mode) && !full && !hs_reg.dcr[DCR_DIR];
        end else if (hs_reg.ofs == OFS_ECR) begin
          hs_next.ecr = {hs_reg.wl[7:2], 2'b00};
          hs_next.tcd = 1'b0;
        end
      end else begin
        hs_next.cnt = hs_reg.cnt + 3'h1;
      end
      H_DONE: if (CS_N || (IOR_N && IOW_N)) begin
        hs_next.st  = H_IDLE;
        hs_next.doe = 1'b0;
      end
      default: hs_next.st = H_IDLE;
    endcase
    // DMA: request when the FIFO can move a byte, drop it once acknowledged.
    if (hs_reg.drq && dack_act) begin
      hs_next.drq = 1'b0;
    end else if (!hs_reg.drq && !dack_act && hs_reg.ecr[ECR_DMAEN] && !hs_reg.tcd
                 && ((mode == M_PFIFO) || (mode == M_ECP)) && DMA_SELECT != SEL_NONE
                 && (hs_reg.dcr[DCR_DIR] ? !empty : !full)) begin
      hs_next.drq = 1'b1;
    end
    if (dack_act && !hs_reg.dcr[DCR_DIR] && IOW_N && !hs_reg.iow_p && !full) begin
      push = 1'b1;
    end
    if (dack_act && hs_reg.dcr[DCR_DIR]) begin
      hs_next.doe   = !IOR_N;
      hs_next.rdata = mif.rd_data;
      pop = IOR_N && !hs_reg.ior_p && !empty;
    end
    if (dack_act && TC) begin
      hs_next.tcd = 1'b1;
    end
    // FIFO pointers; only one writer and one reader can be active per direction.
    mif.wr_en   = push || eng_push;
    mif.wr_addr = hs_reg.wp;
    mif.wr_data = eng_push ? pd_s : hs_reg.wl;
    hs_next.wp   = hs_reg.wp + AW'(mif.wr_en);
    hs_next.rp   = hs_reg.rp + AW'(pop || eng_pop);
    hs_next.fill = hs_reg.fill + (AW+1)'(mif.wr_en) - (AW+1)'(pop || eng_pop);
    if (!mode_fifo(hs_next.ecr[ECR_MODE_LSB +: 3])) begin
      hs_next.wp   = '0;
      hs_next.rp   = '0;
      hs_next.fill = '0;
    end
  end

  // Printer engine: drains the FIFO forward, captures bytes in reverse.
  always_comb begin
    es_next       = es_reg;
    eng_pop       = 1'b0;
    eng_push      = 1'b0;
    es_next.ack_p = ack_s;
    if (mode == M_ECP && hs_reg.dcr[DCR_DIR] && es_reg.ack_p && !ack_s && !full) begin
      eng_push = 1'b1;
    end
    if (tick_reg && es_reg.st != P_IDLE && es_reg.st != P_LOAD) begin
      es_next.tcnt = es_reg.tcnt + 5'h1;
    end
    unique case (es_reg.st)
      P_IDLE: if (fwd && !empty && !busy_s) begin
        es_next.st = P_LOAD;
      end
      P_LOAD: begin
        es_next.pdat = mif.rd_data;
        eng_pop      = 1'b1;
        es_next.tcnt = 5'h0;
        es_next.st   = P_SETUP;
      end
      P_SETUP, P_STROBE, P_HOLD: if (tick_reg && es_reg.tcnt == 5'(STROBE_TICKS - 1)) begin
        es_next.tcnt = 5'h0;
        es_next.st   = (es_reg.st == P_SETUP) ? P_STROBE :
                       (es_reg.st == P_STROBE) ? P_HOLD : P_IDLE;
      end
      default: es_next.st = P_IDLE;
    endcase
  end

  // Pin drivers, all registered.
  always_comb begin
    ps_next.pd_oe  = mode_out_only(mode) || !hs_reg.dcr[DCR_DIR];
    ps_next.dir_ind = !ps_next.pd_oe;
    ps_next.pd     = mode_fifo(mode) ? es_reg.pdat : hs_reg.data;
    ps_next.stb_n  = mode_fifo(mode) ? (es_reg.st != P_STROBE)
                                     : !hs_reg.dcr[DCR_STROBE];
    ps_next.afd_n  = !hs_reg.dcr[DCR_LFEED];
    ps_next.init_n = hs_reg.dcr[DCR_INIT];
    ps_next.sel_n  = !hs_reg.dcr[DCR_SELIN];
    ps_next.irq_n  = {3{!(hs_reg.dcr[DCR_ACKIE] && !ack_s)}};
    ps_next.irq_oe = chan_onehot(IRQ_SELECT);
    ps_next.drq_oe = chan_onehot(DMA_SELECT);
    ps_next.drq    = hs_reg.drq ? chan_onehot(DMA_SELECT) : 3'h0;
  end

  // All state returns to its defaults while reset is high.
  always_ff @(posedge CLK) begin
    if (RST) begin
      hs_reg <= HS_RST;
      es_reg <= ES_RST;
      ps_reg <= PS_RST;
    end else begin
      hs_reg <= hs_next;
      es_reg <= es_next;
      ps_reg <= ps_next;
    end
  end

  assign DATA_OUT                  = hs_reg.rdata;
  assign DATA_OE                   = hs_reg.doe;
  assign IOCHRDY                   = 1'b0;
  assign IOCHRDY_OE                = hs_reg.wt;
  assign DRQ                       = ps_reg.drq;
  assign DRQ_OE                    = ps_reg.drq_oe;
  assign IRQ_N                     = ps_reg.irq_n;
  assign IRQ_OE                    = ps_reg.irq_oe;
  assign PERIPHERAL_DATA_LINES_OUT = ps_reg.pd;
  assign PERIPHERAL_DATA_LINES_OE  = ps_reg.pd_oe;
  assign PORT_DIRECTION_INDICATOR  = ps_reg.dir_ind;
  assign STROBE_N                  = ps_reg.stb_n;
  assign AUTO_LINE_FEED_N          = ps_reg.afd_n;
  assign INIT_N                    = ps_reg.init_n;
  assign PRINTER_SELECT_OUT_N      = ps_reg.sel_n;

  // Checks on the host, DMA and pin behaviour.
  a_ready_wait: assert property (@(posedge CLK) disable iff (RST)
    (hs_reg.st == H_IDLE && host_req) |=> IOCHRDY_OE [*4] ##1 !IOCHRDY_OE)
    else $error("ready wait length wrong");
  a_cs_gate: assert property (@(posedge CLK) disable iff (RST)
    (hs_reg.st == H_IDLE && CS_N) |=> hs_reg.st == H_IDLE)
    else $error("access started without chip select");
  a_drq_hold: assert property (@(posedge CLK) disable iff (RST)
    (hs_reg.drq && !dack_act) |=> hs_reg.drq)
    else $error("dma request dropped before acknowledge");
  a_tc_stop: assert property (@(posedge CLK) disable iff (RST)
    (dack_act && TC) |=> !hs_reg.drq [*3])
    else $error("dma request after terminal count");
  a_reset_mode: assert property (@(posedge CLK) disable iff (RST)
    $past(RST) |-> (mode == M_SPP && PERIPHERAL_DATA_LINES_OE && !PORT_DIRECTION_INDICATOR))
    else $error("not in standard mode after reset");
  a_dir_pair: assert property (@(posedge CLK) disable iff (RST)
    PORT_DIRECTION_INDICATOR != PERIPHERAL_DATA_LINES_OE)
    else $error("direction indicator disagrees with drive");
  a_out_only: assert property (@(posedge CLK) disable iff (RST)
    (mode_out_only(mode) && $stable(mode)) |=> PERIPHERAL_DATA_LINES_OE)
    else $error("forward-only mode not driving");
  a_strobe_data: assert property (@(posedge CLK) disable iff (RST)
    (es_reg.st == P_STROBE && mode_fifo(mode)) |=> (!STROBE_N &&
      PERIPHERAL_DATA_LINES_OUT == $past(es_reg.pdat)))
    else $error("strobe without latched data");
  a_irq_route: assert property (@(posedge CLK) disable iff (RST)
    ##1 IRQ_OE == chan_onehot($past(IRQ_SELECT)) && $onehot0(IRQ_OE))
    else $error("interrupt routed to wrong channel");
  a_fifo_bound: assert property (@(posedge CLK) disable iff (RST)
    hs_reg.fill <= (AW+1)'(DEPTH))
    else $error("fifo overfilled");
endmodule : ppp_port
